//--- src/rlfc_top.sv
// color led flash control: registers, output gating, flash mode and safety timer
// Operation
// - non-overlapping frame stays fixed; on times shrink with brightness, tail stays off
// - red, green, blue get separate slots, ratios from sixteen color codes
// - outputs enabled, internal pwm off: each output follows its switch bit
// - direct mode ignores color and brightness settings
// - output mode bit high selects switch mode, low current sink; reset switch
// - max current register holds red 5:4, green 3:2, blue 1:0 codes
// - current codes 00..11 scale the ceiling to quarter, half, three quarters, full
// - pin acts as pwm input only with pin-pwm enable and outputs enabled
// - external pwm gates only selected, switched-on outputs; pin high means on
// - internal pwm off follows pin; on, internal pwm passes while pin high
// - unselected enabled outputs stay on whatever the pin does
// - flash pulse drives selected outputs at full current, overriding codes, switches
// - flash outputs shut off after the pin falls ending the pulse
// - new pulse needs flash enable cleared and set again
// - safety mode trips when max current register not accessed for one second
// - control bits: internal pwm 7, enable 6, mode 5, switches 3..1
// - trip switches off safety-enabled outputs and sets a read-only status bit
// - in flash mode safety counter runs only while the pin is high
`timescale 1ns/100ps
`include "rlfc_cfg.svh"
module rlfc_top #(
	parameter int FRAME_CYC  = `RLFC_FRAME_CYC,
	parameter int SAFETY_CYC = `RLFC_SAFETY_CYC
) (
	input  wire logic              mclk,
	input  wire logic              rstn,
	input  wire logic              pwm_pin,
	input  wire rlfc_pkg::rlfc_regreq_t reg_req,
	output logic             [7:0] reg_rdata,
	output rlfc_pkg::rlfc_led_t    led_on,
	output rlfc_pkg::rlfc_code_t   led_code,
	output logic                   switch_mode
);
	localparam int CW = $clog2(SAFETY_CYC + 1);

	if (SAFETY_CYC < 2) begin : g_chk
		$error("safety time must span at least two cycles");
	end

	logic                  rst_meta;
	logic                  rst_n;
	logic                  pin_meta;
	logic                  pin_s;
	logic [7:0]            ctrl_reg;
	logic [7:0]            color_reg;
	logic [7:0]            maxcur_reg;
	logic [7:0]            gpio_reg;
	logic [6:0]            flash_reg;
	logic                  trip_reg;
	logic [CW-1:0]         cnt_reg;
	rlfc_pkg::rlfc_flash_t st_reg;
	rlfc_pkg::rlfc_flash_t st_next;
	logic [2:0]            pwm;
	logic [2:0]            on_next;
	logic [5:0]            code_next;
	logic [7:0]            rd_mux;

	// reset release through two flip-flops
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// pin synchroniser; only pin_s is read
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta <= 1'b0;
			pin_s    <= 1'b0;
		end else begin
			pin_meta <= pwm_pin;
			pin_s    <= pin_meta;
		end
	end

	// named control fields
	wire       ipwm     = ctrl_reg[`RLFC_CTRL_IPWM];
	wire       col_en   = ctrl_reg[`RLFC_CTRL_EN];
	wire [2:0] sw       = ctrl_reg[`RLFC_CTRL_SW_HI:`RLFC_CTRL_SW_LO];
	wire [2:0] ext_sel  = flash_reg[`RLFC_FLASH_SEL_HI:`RLFC_FLASH_SEL_LO];
	wire [2:0] saf_en   = flash_reg[`RLFC_FLASH_SAF_HI:`RLFC_FLASH_SAF_LO];
	wire       fen      = flash_reg[`RLFC_FLASH_EN];
	wire       saf_any  = |saf_en;
	wire       pin_gate = gpio_reg[`RLFC_GPIO_PIN_PWM] & col_en;
	wire [2:0] ext_path = ext_sel & {3{pin_gate & ~fen}};
	wire [2:0] fl_path  = ext_sel & {3{pin_gate & fen}};
	wire [2:0] kill     = saf_en & {3{trip_reg}};
	wire [2:0] base     = ipwm ? (sw & pwm) : sw;
	wire       acc_max  = (reg_req.wr | reg_req.rd) && (reg_req.addr == `RLFC_ADDR_MAXCUR);
	wire       cnt_en   = saf_any & ~trip_reg & (fen ? pin_s : 1'b1);
	wire       cnt_end  = cnt_en && (cnt_reg == CW'(SAFETY_CYC - 1));

	rlfc_slot_pwm #(
		.FRAME_CYC (FRAME_CYC)
	) u_slot (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.color   (color_reg[`RLFC_COLOR_HI:`RLFC_COLOR_LO]),
		.bright  (color_reg[`RLFC_BRIGHT_HI:`RLFC_BRIGHT_LO]),
		.overlap (color_reg[`RLFC_COLOR_OVL]),
		.pwm_reg (pwm)
	);

	// register writes; the trip bit is not writable
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg   <= `RLFC_CTRL_RESET;
			color_reg  <= `RLFC_REG_RESET;
			maxcur_reg <= `RLFC_REG_RESET;
			gpio_reg   <= `RLFC_REG_RESET;
			flash_reg  <= 7'h00;
		end else if (reg_req.wr) begin
			case (reg_req.addr)
				`RLFC_ADDR_CTRL:   ctrl_reg   <= reg_req.wdata & 8'hEE;
				`RLFC_ADDR_COLOR:  color_reg  <= reg_req.wdata;
				`RLFC_ADDR_MAXCUR: maxcur_reg <= reg_req.wdata & 8'h3F;
				`RLFC_ADDR_GPIO:   gpio_reg   <= reg_req.wdata & 8'h01;
				`RLFC_ADDR_FLASH:  flash_reg  <= reg_req.wdata[6:0];
				default: ;
			endcase
		end
	end

	// read data, zero for unmapped addresses
	assign rd_mux =
		(reg_req.addr == `RLFC_ADDR_CTRL)   ? ctrl_reg :
		(reg_req.addr == `RLFC_ADDR_COLOR)  ? color_reg :
		(reg_req.addr == `RLFC_ADDR_MAXCUR) ? maxcur_reg :
		(reg_req.addr == `RLFC_ADDR_GPIO)   ? gpio_reg :
		(reg_req.addr == `RLFC_ADDR_FLASH)  ? {trip_reg, flash_reg} : 8'h00;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_req.rd) begin
			reg_rdata <= rd_mux;
		end
	end

	// flash sequencer: arm on enable with pin low, one pulse per arming
	always_comb begin
		st_next = st_reg;
		case (st_reg)
			rlfc_pkg::RLFC_F_IDLE: begin
				if (fen && !pin_s) st_next = rlfc_pkg::RLFC_F_ARMED;
			end
			rlfc_pkg::RLFC_F_ARMED: begin
				if (!fen) st_next = rlfc_pkg::RLFC_F_IDLE;
				else if (pin_s) st_next = rlfc_pkg::RLFC_F_PULSE;
			end
			rlfc_pkg::RLFC_F_PULSE: begin
				if (!fen) st_next = rlfc_pkg::RLFC_F_IDLE;
				else if (!pin_s) st_next = rlfc_pkg::RLFC_F_DONE;
			end
			rlfc_pkg::RLFC_F_DONE: begin
				if (!fen) st_next = rlfc_pkg::RLFC_F_IDLE;
			end
			default: st_next = rlfc_pkg::RLFC_F_IDLE;
		endcase
	end

	// safety counter and trip flag; only clearing all safety bits resets a trip
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg   <= rlfc_pkg::RLFC_F_IDLE;
			cnt_reg  <= '0;
			trip_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			if (!saf_any) begin
				cnt_reg  <= '0;
				trip_reg <= 1'b0;
			end else if (acc_max && !fen && !trip_reg) begin
				cnt_reg <= '0;
			end else if (cnt_en) begin
				cnt_reg <= cnt_reg + CW'(1);
				if (cnt_end) trip_reg <= 1'b1;
			end
		end
	end

	// per-output gating: direct, external pwm, flash override, safety cut
	always_comb begin
		on_next   = 3'h0;
		code_next = maxcur_reg[5:0];
		for (int i = 0; i < 3; i++) begin
			if (col_en) begin
				if (fl_path[i]) begin
					if (st_reg == rlfc_pkg::RLFC_F_PULSE) begin
						on_next[i]          = 1'b1;
						code_next[2*i +: 2] = `RLFC_FULL_CODE;
					end else if (st_reg != rlfc_pkg::RLFC_F_DONE) begin
						on_next[i] = base[i];
					end
				end else if (ext_path[i]) begin
					on_next[i] = base[i] & pin_s;
				end else begin
					on_next[i] = base[i];
				end
				if (kill[i]) on_next[i] = 1'b0;
			end
		end
	end

	// registered outputs
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			led_on      <= '0;
			led_code    <= '0;
			switch_mode <= 1'b1;
		end else begin
			led_on      <= on_next;
			led_code    <= code_next;
			switch_mode <= ctrl_reg[`RLFC_CTRL_MODE];
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_disabled_off: assert property (!$past(col_en) |-> led_on == '0)
		else $error("output on while color outputs disabled");
	a_direct_switch: assert property ($past(col_en && !ipwm && !pin_gate && !trip_reg)
		|-> led_on == $past(sw))
		else $error("direct mode output differs from switch bits");
	a_mode_follow: assert property (switch_mode == $past(ctrl_reg[`RLFC_CTRL_MODE]))
		else $error("output mode does not follow mode bit");
	a_code_map: assert property ($past(st_reg != rlfc_pkg::RLFC_F_PULSE)
		|-> led_code == $past(maxcur_reg[5:0]))
		else $error("current code not taken from max current register");
	a_ext_gate: assert property ($past(ext_path[2] && col_en && !ipwm && !kill[2])
		|-> led_on.red_output == $past(sw[2] & pin_s))
		else $error("red output not gated by external pin");
	a_unsel_on: assert property ($past(pin_gate && !ext_sel[1] && !ipwm && sw[1] && !kill[1])
		|-> led_on.green_output)
		else $error("unselected green output not held on");
	a_flash_full: assert property ((st_reg == rlfc_pkg::RLFC_F_PULSE) && fl_path[0] && !kill[0]
		|=> led_on.blue_output && (led_code.blue_current_code == `RLFC_FULL_CODE))
		else $error("blue not at full current during flash pulse");
	a_flash_end: assert property ((st_reg == rlfc_pkg::RLFC_F_PULSE) && fen && !pin_s
		##1 fl_path[2] |=> !led_on.red_output)
		else $error("flash output still on after pulse end");
	a_no_rearm: assert property (st_reg == rlfc_pkg::RLFC_F_DONE
		|=> st_reg inside {rlfc_pkg::RLFC_F_DONE, rlfc_pkg::RLFC_F_IDLE})
		else $error("second pulse accepted without re-enabling flash");
	a_safety_trip: assert property (cnt_end && saf_any |=> trip_reg)
		else $error("safety counter end did not trip");
	a_safety_cut: assert property ($past(trip_reg && saf_en[2]) |-> !led_on.red_output)
		else $error("safety enabled output on after trip");
	a_count_hold: assert property (fen && !pin_s && saf_any && !$past(!saf_any)
		|=> $stable(cnt_reg))
		else $error("safety counter moved with pin low in flash mode");

	c_flash_pulse: cover property (st_reg == rlfc_pkg::RLFC_F_ARMED ##1
		st_reg == rlfc_pkg::RLFC_F_PULSE);
	c_flash_done: cover property (st_reg == rlfc_pkg::RLFC_F_PULSE ##1
		st_reg == rlfc_pkg::RLFC_F_DONE);
	c_safety_trip: cover property ($rose(trip_reg));
	c_ext_gate: cover property (ext_path[2] && pin_s ##1 !pin_s);
endmodule

//--- src/rlfc_cfg.svh
// offsets, field positions, reset values and timing for the color led flash control
`ifndef RLFC_CFG_SVH
`define RLFC_CFG_SVH
`define RLFC_ADDR_CTRL     8'h00
`define RLFC_ADDR_COLOR    8'h01
`define RLFC_ADDR_MAXCUR   8'h02
`define RLFC_ADDR_GPIO     8'h06
`define RLFC_ADDR_FLASH    8'h07
`define RLFC_CTRL_IPWM     7
`define RLFC_CTRL_EN       6
`define RLFC_CTRL_MODE     5
`define RLFC_CTRL_SW_HI    3
`define RLFC_CTRL_SW_LO    1
`define RLFC_COLOR_HI      7
`define RLFC_COLOR_LO      4
`define RLFC_BRIGHT_HI     3
`define RLFC_BRIGHT_LO     1
`define RLFC_COLOR_OVL     0
`define RLFC_GPIO_PIN_PWM  0
`define RLFC_FLASH_SEL_HI  2
`define RLFC_FLASH_SEL_LO  0
`define RLFC_FLASH_EN      3
`define RLFC_FLASH_SAF_HI  6
`define RLFC_FLASH_SAF_LO  4
`define RLFC_FLASH_TRIP    7
`define RLFC_CTRL_RESET    8'h20
`define RLFC_REG_RESET     8'h00
`define RLFC_FULL_CODE     2'h3
`define RLFC_CLK_NS        20
`define RLFC_FRAME_NS      50000
`define RLFC_SAFETY_NS     1000000000
`define RLFC_FRAME_CYC     (`RLFC_FRAME_NS / `RLFC_CLK_NS)
`define RLFC_SAFETY_CYC    (`RLFC_SAFETY_NS / `RLFC_CLK_NS)
`endif

//--- src/rlfc_pkg.sv
// types shared by the color led flash control
package rlfc_pkg;
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rlfc_regreq_t;

	typedef struct packed {
		logic red_output;
		logic green_output;
		logic blue_output;
	} rlfc_led_t;

	typedef struct packed {
		logic [1:0] red_current_code;
		logic [1:0] green_current_code;
		logic [1:0] blue_current_code;
	} rlfc_code_t;

	typedef enum logic [3:0] {
		RLFC_F_IDLE  = 4'h1,
		RLFC_F_ARMED = 4'h2,
		RLFC_F_PULSE = 4'h4,
		RLFC_F_DONE  = 4'h8
	} rlfc_flash_t;
endpackage

//--- src/rlfc_slot_pwm.sv
// internal pwm frame generator: color slots and brightness scaling
`timescale 1ns/100ps
`include "rlfc_cfg.svh"
module rlfc_slot_pwm #(
	parameter int FRAME_CYC = `RLFC_FRAME_CYC
) (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic [3:0] color,
	input  wire logic [2:0] bright,
	input  wire logic       overlap,
	output logic      [2:0] pwm_reg
);
	localparam int PW = $clog2(FRAME_CYC + 1); // full-brightness length FRAME_CYC must fit too
	localparam int MW = PW + 4;

	if (FRAME_CYC < 128) begin : g_chk
		$error("frame too short for 1/64 brightness");
	end

	logic [PW-1:0] pos_reg;
	logic [PW-1:0] bl;
	logic [11:0]   parts;
	logic [MW-1:0] pos_x;
	logic [MW-1:0] e1;
	logic [MW-1:0] e2;
	logic [MW-1:0] e3;
	logic [2:0]    pwm_next;

	// on length of a frame for a brightness step, halving per step
	function automatic logic [PW-1:0] bright_len(input logic [2:0] b);
		bright_len = (b == 3'h0) ? '0 : PW'(FRAME_CYC >> (3'h7 - b));
	endfunction

	// share of each color in twelfths: red, green, blue nibbles
	function automatic logic [11:0] color_parts(input logic [3:0] c);
		case (c)
			4'h0: color_parts = 12'hC00;
			4'h1: color_parts = 12'h0C0;
			4'h2: color_parts = 12'h00C;
			4'h3: color_parts = 12'h660;
			4'h4: color_parts = 12'h066;
			4'h5: color_parts = 12'h606;
			4'h6: color_parts = 12'h444;
			4'h7: color_parts = 12'h633;
			4'h8: color_parts = 12'h363;
			4'h9: color_parts = 12'h363;
			4'hA: color_parts = 12'h336;
			4'hB: color_parts = 12'h930;
			4'hC: color_parts = 12'h093;
			4'hD: color_parts = 12'h390;
			4'hE: color_parts = 12'h039;
			default: color_parts = 12'h309;
		endcase
	endfunction

	// slot edges in twelfths of a frame position
	assign bl    = bright_len(bright);
	assign parts = color_parts(color);
	assign pos_x = MW'(pos_reg) * MW'(4'hC);
	assign e1    = MW'(bl) * MW'(parts[11:8]);
	assign e2    = MW'(bl) * (MW'(parts[11:8]) + MW'(parts[7:4]));
	assign e3    = MW'(bl) * (MW'(parts[11:8]) + MW'(parts[7:4]) + MW'(parts[3:0]));
	assign pwm_next = overlap ? {3{pos_reg < bl}} :
		{pos_x < e1, (pos_x >= e1) && (pos_x < e2), (pos_x >= e2) && (pos_x < e3)};

	// fixed frame counter and registered slot outputs
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pos_reg <= '0;
			pwm_reg <= 3'h0;
		end else begin
			pos_reg <= (pos_reg == PW'(FRAME_CYC - 1)) ? '0 : pos_reg + PW'(1);
			pwm_reg <= pwm_next;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_frame_length: assert property (pos_reg == PW'(FRAME_CYC - 1) |=> pos_reg == '0)
		else $error("frame did not wrap at its fixed length");
	a_slots_apart: assert property (!$past(overlap) |-> $onehot0(pwm_reg))
		else $error("color slots overlap");
	a_half_tail_off: assert property (($past(bright) == 3'h6) && ($past(pos_reg) >= PW'(FRAME_CYC / 2))
		|-> pwm_reg == 3'h0)
		else $error("output on in tail of half brightness frame");
	c_red_slot: cover property (!overlap && (color == 4'h6) && pwm_reg[2] ##1 pwm_reg[1]);
endmodule

//--- bench/rlfc_host.sv
// host model: register strobes and the flash trigger pin
`timescale 1ns/100ps
module rlfc_host (
	input  wire logic              mclk,
	input  wire logic        [7:0] reg_rdata,
	output rlfc_pkg::rlfc_regreq_t reg_req,
	output logic                   pwm_pin
);
	// bus idle and pin low from time zero, so flash can be armed
	initial begin
		reg_req = '0;
		pwm_pin = 1'b0;
	end

	// one-cycle write strobe, launched on the falling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge mclk);
		reg_req = {1'b1, 1'b0, a, v};
		@(negedge mclk);
		reg_req = '0;
	endtask

	// one-cycle read strobe, data taken once the read edge has passed
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(negedge mclk);
		reg_req = {1'b0, 1'b1, a, 8'h00};
		@(negedge mclk);
		reg_req = '0;
		v = reg_rdata;
	endtask

	// set the pin level and hold it for n cycles
	task automatic pin(input logic v, input int n);
		@(negedge mclk);
		pwm_pin = v;
		repeat (n) @(negedge mclk);
	endtask

	// flash preparation: pre-flash codes, outputs on, arm with pin low, select
	task automatic arm(input logic [7:0] ctrl, input logic [7:0] sel);
		wr(8'h02, 8'h00);
		wr(8'h00, 8'h40);
		wr(8'h07, 8'h08);
		wr(8'h06, 8'h01);
		wr(8'h00, ctrl);
		wr(8'h07, 8'h08 | sel);
	endtask

	// flash enable low then high again before the next pulse
	task automatic rearm(input logic [7:0] f);
		wr(8'h07, f);
		wr(8'h07, f | 8'h08);
	endtask
endmodule

//--- bench/rlfc_top_bench.sv
// self-checking bench for the color led flash control
`timescale 1ns/100ps
module rlfc_top_bench;
	localparam int FRAME = 256;
	localparam int SAFE  = 200;
	logic                   mclk = 1'b0;
	logic                   rstn = 1'b0;
	logic             [7:0] rdata;
	logic             [7:0] d;
	rlfc_pkg::rlfc_regreq_t req;
	rlfc_pkg::rlfc_led_t    led;
	rlfc_pkg::rlfc_code_t   code;
	logic                   swm;
	logic                   pin;
	int                     num_errors = 0;
	int                     comparisons = 0;
	int                     cycles = 0;
	logic            [15:0] tbl [6][4];
	logic             [7:0] cur [3];

	rlfc_top #(.FRAME_CYC(FRAME), .SAFETY_CYC(SAFE)) dut (
		.mclk        (mclk),
		.rstn        (rstn),
		.pwm_pin     (pin),
		.reg_req     (req),
		.reg_rdata   (rdata),
		.led_on      (led),
		.led_code    (code),
		.switch_mode (swm)
	);

	rlfc_host host (
		.mclk      (mclk),
		.reg_rdata (rdata),
		.reg_req   (req),
		.pwm_pin   (pin)
	);

	// clock and hang guard
	always #10 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			complete_run();
		end
	end

	task automatic complete_run;
		if (num_errors == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, d);
		chk({8'h00, d}, {8'h00, e});
	endtask

	// let register and pin latency pass, then compare the outputs
	task automatic lchk(input logic [2:0] e);
		repeat (4) @(negedge mclk);
		chk({13'h0000, led}, {13'h0000, e});
	endtask

	// count on cycles over one full frame, flag any two colors on together
	task automatic frame(input logic [15:0] r, input logic [15:0] g, input logic [15:0] b);
		int   c [3];
		logic ov;
		c = '{0, 0, 0};
		ov = 1'b0;
		repeat (FRAME) @(negedge mclk);
		repeat (FRAME) begin
			@(negedge mclk);
			c[0] += int'(led.red_output);
			c[1] += int'(led.green_output);
			c[2] += int'(led.blue_output);
			ov |= ($countones(led) > 1);
		end
		chk(16'(c[0]), r);
		chk(16'(c[1]), g);
		chk(16'(c[2]), b);
		chk({15'h0000, ov}, 16'h0000);
	endtask

	initial begin
		// color register, then red/green/blue on counts at 256-cycle frame
		tbl = '{'{16'h000E, 16'h0100, 16'h0000, 16'h0000},
			'{16'h000C, 16'h0080, 16'h0000, 16'h0000},
			'{16'h003C, 16'h0040, 16'h0040, 16'h0000},
			'{16'h007E, 16'h0080, 16'h0040, 16'h0040},
			'{16'h002A, 16'h0000, 16'h0000, 16'h0040},
			'{16'h00EE, 16'h0000, 16'h0040, 16'h00C0}};
		cur = '{8'h00, 8'h1B, 8'h3F};
		repeat (3) @(negedge mclk);
		rstn = 1'b1;
		repeat (4) @(negedge mclk);
		chk({15'h0000, swm}, 16'h0001);
		chk({13'h0000, led}, 16'h0000);
		rchk(8'h00, 8'h20);
		rchk(8'h02, 8'h00);
		host.wr(8'h02, 8'hFF);
		rchk(8'h02, 8'h3F);
		host.wr(8'h05, 8'hFF);
		rchk(8'h05, 8'h00);
		// direct switching with a color setting loaded that must not matter
		host.wr(8'h01, 8'h6F);
		for (int i = 0; i < 8; i++) begin
			host.wr(8'h00, 8'h40 | 8'(i << 1));
			lchk(3'(i));
		end
		chk({15'h0000, swm}, 16'h0000);
		// register-stepped flash: pre-flash codes, full codes, switches off
		host.wr(8'h00, 8'h4E);
		foreach (cur[k]) begin
			host.wr(8'h02, cur[k]);
			lchk(3'h7);
			chk({10'h000, code}, {8'h00, cur[k]});
		end
		host.wr(8'h00, 8'h40);
		lchk(3'h0);
		// external pwm: red and blue selected, blue switch off
		host.wr(8'h06, 8'h01);
		host.wr(8'h07, 8'h05);
		host.wr(8'h00, 8'h4C);
		lchk(3'h2);
		host.pin(1'b1, 0);
		lchk(3'h6);
		host.pin(1'b0, 0);
		host.wr(8'h06, 8'h00);
		lchk(3'h6);
		// internal slots, pin unused
		host.wr(8'h07, 8'h00);
		host.wr(8'h00, 8'hCE);
		foreach (tbl[k]) begin
			host.wr(8'h01, tbl[k][0][7:0]);
			frame(tbl[k][1], tbl[k][2], tbl[k][3]);
		end
		// overlapping mode at full brightness keeps every switched output on
		host.wr(8'h01, 8'h0F);
		lchk(3'h7);
		// internal pwm gated by the pin on the selected red output
		host.wr(8'h01, 8'h0C);
		host.wr(8'h06, 8'h01);
		host.wr(8'h07, 8'h04);
		host.wr(8'h00, 8'hC8);
		frame(16'h0000, 16'h0000, 16'h0000);
		host.pin(1'b1, 0);
		frame(16'h0080, 16'h0000, 16'h0000);
		host.pin(1'b0, 0);
		// flash mode on blue with its switch off
		host.arm(8'h4C, 8'h01);
		lchk(3'h6);
		host.pin(1'b1, 0);
		lchk(3'h7);
		chk({10'h000, code}, 16'h0003);
		host.pin(1'b0, 0);
		lchk(3'h6);
		host.pin(1'b1, 0);
		lchk(3'h6);
		host.pin(1'b0, 0);
		host.rearm(8'h01);
		host.pin(1'b1, 0);
		lchk(3'h7);
		host.pin(1'b0, 0);
		// safety with flash off: accesses to max current keep it alive
		host.wr(8'h07, 8'h80);
		rchk(8'h07, 8'h00);
		host.wr(8'h00, 8'h4E);
		host.wr(8'h07, 8'h40);
		repeat (3) begin
			repeat (150) @(negedge mclk);
			host.rd(8'h02, d);
		end
		lchk(3'h7);
		repeat (SAFE) @(negedge mclk);
		lchk(3'h3);
		rchk(8'h07, 8'hC0);
		host.wr(8'h07, 8'h00);
		lchk(3'h7);
		// safety with flash on: counts only during pulses
		host.arm(8'h4E, 8'h04);
		host.wr(8'h07, 8'h4C);
		host.pin(1'b1, 120);
		lchk(3'h7);
		host.pin(1'b0, 300);
		rchk(8'h07, 8'h4C);
		host.rearm(8'h44);
		host.pin(1'b1, 120);
		lchk(3'h3);
		rchk(8'h07, 8'hCC);
		host.pin(1'b0, 0);
		complete_run();
	end
endmodule
